// *** rtl/sew_access.sv ***
// Purpose: access logic of a 16-word serial nonvolatile word memory
// Assumes: SHIFT_CLK comes from the controller and may stand still between frames
// Notes: serial_out is open drain and is driven only during a read
`timescale 1ns/1ps
module sew_access
   import sew_pkg::*;
#(
   parameter logic [TMR_W-1:0] SETTLE_CYC = TMR_W'(SETTLE_CYC_DEF),
   parameter logic [TMR_W-1:0] PROG_CYC = TMR_W'(PROG_CYC_DEF),
   parameter int FIRST_BIT_LIMIT = FIRST_BIT_CYC
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic HARD_CLEAR_N,
   // controller requests
   input wire logic FETCH_REQUEST_N,
   input wire logic SAVE_REQUEST_N,
   input wire logic [sew_pkg::ADDR_W-1:0] WORD_INDEX,
   input wire logic WORD_SIZE_STRAP,
   // serial link
   input wire logic SHIFT_CLK,
   input wire logic SERIAL_IN,
   output logic SERIAL_OUT_O,
   output logic SERIAL_OUT_OE,
   // status
   output logic PROGRAM_BUSY,
   output logic CLEAR_IND_N
);
   import sew_pkg::*;

   // refuse timings the logic cannot meet
   if (SETTLE_CYC < 1 || PROG_CYC < 1 || FIRST_BIT_LIMIT < OUT_LATENCY_CYC) begin : g_bad_timing
      $error("sew_access: timing parameters out of range");
   end

   function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
      logic [CNT_W-1:0] b;
      b = g;
      for (int i = CNT_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   function automatic logic [CNT_W-1:0] word_len(input logic strap);
      return (strap == STRAP_LONG) ? CNT_W'(WORD_LONG) : CNT_W'(WORD_SHORT);
   endfunction

   // link side: counts falling shift clock edges and keeps the last 32 bits it saw
   logic lrst_m_q;
   logic lrst_s_q;
   logic [CNT_W-1:0] lcnt_q;
   logic [CNT_W-1:0] lgray_q;
   logic [CNT_W-1:0] lcnt_nx;
   logic lbits_q [2**CNT_W];

   assign lcnt_nx = lcnt_q + 1'b1;

   // reset reaches the link side only through its own two flops
   always_ff @(negedge SHIFT_CLK) begin
      lrst_m_q <= RST_B;
      lrst_s_q <= lrst_m_q;
   end

   // free running gray pointer; frames are measured as distances, so no frame reset is needed
   always_ff @(negedge SHIFT_CLK) begin
      if (!lrst_s_q) begin
         lcnt_q <= CNT_RST;
         lgray_q <= CNT_RST;
      end else begin
         lcnt_q <= lcnt_nx;
         lgray_q <= lcnt_nx ^ (lcnt_nx >> 1);
      end
   end

   // each bit lands in its own slot and stays until the pointer wraps
   always_ff @(negedge SHIFT_CLK) begin
      lbits_q[lcnt_q] <= SERIAL_IN;
   end

   // pin and pointer synchronisers
   logic [7:0] pin_m_q;
   logic [7:0] pin_s_q;
   logic [CNT_W-1:0] gray_m_q;
   logic [CNT_W-1:0] gray_s_q;

   always_ff @(posedge REF_CLK) begin
      pin_m_q <= {HARD_CLEAR_N, WORD_SIZE_STRAP, WORD_INDEX, SAVE_REQUEST_N, FETCH_REQUEST_N};
      pin_s_q <= pin_m_q;
      gray_m_q <= lgray_q;
      gray_s_q <= gray_m_q;
   end

   logic fetch_s;
   logic save_s;
   logic [ADDR_W-1:0] idx_s;
   logic strap_s;
   logic hard_s;
   logic clr;
   assign fetch_s = pin_s_q[0];
   assign save_s = pin_s_q[1];
   assign idx_s = pin_s_q[5:2];
   assign strap_s = pin_s_q[6];
   assign hard_s = pin_s_q[7];
   assign clr = !RST_B || !hard_s;

   // control state
   sew_state_t state_q, state_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [CNT_W-1:0] base_q, base_d;
   logic [CNT_W-1:0] len_q, len_d;
   logic busy_q, busy_d;
   logic blk_q, blk_d;
   logic oe_q;
   logic sout_q, sout_d;
   logic clr_ind_q;
   logic fetch_p_q;
   logic save_p_q;
   logic [WORD_LONG-1:0] mem_q [WORDS];

   // request edges from the synchronised pins
   logic fetch_fall;
   logic fetch_rise;
   logic save_fall;
   logic idle;
   logic start_read;
   logic start_save;
   assign fetch_fall = fetch_p_q && !fetch_s;
   assign fetch_rise = !fetch_p_q && fetch_s;
   assign save_fall = save_p_q && !save_s;
   assign idle = (state_q == SEW_IDLE);
   assign start_read = idle && fetch_fall;
   // read wins a tie; a blocked store edge is simply dropped
   assign start_save = idle && save_fall && !fetch_fall && !blk_q;

   // link position inside the current frame
   logic [CNT_W-1:0] cur_cnt;
   logic [CNT_W-1:0] rel;
   logic frame_done;
   logic settle_done;
   logic prog_done;
   assign cur_cnt = gray2bin(gray_s_q);
   assign rel = cur_cnt - base_q;
   assign frame_done = (rel >= len_q);
   assign settle_done = (tmr_q >= SETTLE_CYC);
   assign prog_done = (tmr_q >= PROG_CYC);

   // read bit select; clocks past the word length keep the last bit
   logic [CNT_W-1:0] bit_k;
   logic [CNT_W-1:0] bit_pos;
   logic [WORD_LONG-1:0] mem_rd;
   logic rd_bit;
   logic first_bit;
   assign bit_k = frame_done ? (len_q - 1'b1) : rel;
   assign bit_pos = len_q - 1'b1 - bit_k;
   assign mem_rd = mem_q[addr_q];
   assign rd_bit = mem_rd[bit_pos[ADDR_W-1:0]];
   assign first_bit = mem_rd[4'(len_q - 1'b1)];

   // word assembly; the link side stops writing these slots once the word is in,
   // so reading them after the synchronised pointer arrives is safe
   logic [WORD_LONG-1:0] asm_word;
   for (genvar j = 0; j < WORD_LONG; j++) begin : g_asm
      logic [CNT_W-1:0] ix;
      assign ix = base_q + len_q - CNT_W'(j + 1);
      assign asm_word[j] = (CNT_W'(j) < len_q) && lbits_q[ix];
   end

   // buffer between the shift stage and the erase and write engine
   sew_word_t buf_in;
   sew_word_t buf_out;
   logic buf_in_ready;
   logic buf_out_valid;
   logic push;
   logic pop;
   assign buf_in = '{addr: addr_q, data: asm_word};
   assign push = (state_q == SEW_SHIFT) && frame_done && buf_in_ready;
   assign pop = (state_q == SEW_PROG) && prog_done && buf_out_valid;

   sew_buf #(
      .WIDTH($bits(sew_word_t)),
      .DEPTH(2)
   ) u_buf (
      .clk(REF_CLK),
      .rst_b(!clr),
      .in_valid(push),
      .in_ready(buf_in_ready),
      .in_data(buf_in),
      .out_valid(buf_out_valid),
      .out_ready(pop),
      .out_data(buf_out)
   );

   // next state; the idle decoder is shut outside SEW_IDLE, so nothing is taken while busy is high
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         SEW_IDLE: begin
            if (start_read) begin
               state_d = SEW_READ;
            end else if (start_save) begin
               state_d = SEW_SHIFT;
            end
         end
         SEW_READ: begin
            if (fetch_rise) begin
               state_d = SEW_IDLE;
            end
         end
         SEW_SHIFT: begin
            if (push) begin
               state_d = SEW_PROG;
            end
         end
         SEW_PROG: begin
            if (pop) begin
               state_d = SEW_IDLE;
            end
         end
      endcase
   end

   // datapath selections
   logic tmr_clr;
   assign tmr_clr = start_read || start_save || push;
   assign tmr_d = tmr_clr ? '0 : ((tmr_q != TMR_MAX) ? tmr_q + 1'b1 : tmr_q);
   // in a read, address follows the pins until the settling time runs out, then freezes
   assign addr_d = (start_read || start_save) ? idx_s :
                   (state_q == SEW_READ && !settle_done) ? idx_s : addr_q;
   assign base_d = (start_read || start_save) ? cur_cnt : base_q;
   assign len_d = (start_read || start_save) ? word_len(strap_s) : len_q;
   assign busy_d = start_save ? 1'b1 : (pop ? 1'b0 : busy_q);
   // completion sets the block; the set wins over a fetch rise in the same cycle
   assign blk_d = pop || (blk_q && !fetch_rise);
   assign sout_d = (state_d == SEW_READ) ? rd_bit : SOUT_IDLE;

   // control registers
   always_ff @(posedge REF_CLK) begin
      if (clr) begin
         state_q <= SEW_IDLE;
         tmr_q <= '0;
         addr_q <= '0;
         base_q <= CNT_RST;
         len_q <= CNT_RST;
         busy_q <= BUSY_RST;
         blk_q <= 1'b0;
         oe_q <= OE_RST;
         sout_q <= SOUT_IDLE;
         fetch_p_q <= 1'b1;
         save_p_q <= 1'b1;
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
         addr_q <= addr_d;
         base_q <= base_d;
         len_q <= len_d;
         busy_q <= busy_d;
         blk_q <= blk_d;
         oe_q <= (state_d == SEW_READ);
         sout_q <= sout_d;
         fetch_p_q <= fetch_s;
         save_p_q <= save_s;
      end
   end

   // clear indicator mirrors the combined reset
   always_ff @(posedge REF_CLK) begin
      clr_ind_q <= clr ? CLR_IND_RST : 1'b1;
   end

   // nonvolatile contents survive reset, so the array has none
   always_ff @(posedge REF_CLK) begin
      if (pop) begin
         mem_q[buf_out.addr] <= buf_out.data;
      end
   end

   assign SERIAL_OUT_O = sout_q;
   assign SERIAL_OUT_OE = oe_q;
   assign PROGRAM_BUSY = busy_q;
   assign CLEAR_IND_N = clr_ind_q;

   // checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (clr);

   a_first_bit_out: assert property (start_read ##1 !fetch_rise |=> oe_q && sout_q == $past(first_bit))
      else $error("first bit not presented after read start");
   a_read_drives: assert property ((state_q == SEW_READ) && !fetch_s |-> oe_q)
      else $error("serial output released during read");
   a_idle_release: assert property ((state_q != SEW_READ) |-> !oe_q)
      else $error("serial output driven outside a read");
   a_addr_frozen: assert property ($past(settle_done && state_q == SEW_READ) && state_q == SEW_READ
      |-> $stable(addr_q))
      else $error("address changed after settling window");
   a_read_ends: assert property ((state_q == SEW_READ) && fetch_rise |=> idle)
      else $error("read did not end on fetch rise");
   a_busy_raise: assert property (start_save |=> busy_q && state_q == SEW_SHIFT)
      else $error("busy not raised at rewrite start");
   a_busy_fall: assert property ($fell(busy_q) |-> $past(state_q == SEW_PROG && prog_done))
      else $error("busy fell before erase and write time");
   a_prog_start: assert property ((state_q == SEW_SHIFT) && frame_done && buf_in_ready
      |=> state_q == SEW_PROG && tmr_q == '0)
      else $error("programming did not follow the last data clock");
   a_save_blocked: assert property (blk_q && idle && save_fall && !fetch_fall |=> !busy_q ##1 !busy_q)
      else $error("store accepted while blocked");
   a_len_strap: assert property ((start_read || start_save)
      |=> len_q == (($past(strap_s) == STRAP_LONG) ? CNT_W'(WORD_LONG) : CNT_W'(WORD_SHORT)))
      else $error("word length does not follow strap");
   a_clear_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      !hard_s |=> !clr_ind_q && idle && !busy_q)
      else $error("hard clear not holding reset");

   c_read_done: cover property ((state_q == SEW_READ) && rel == len_q ##[1:1000] fetch_rise);
   c_prog_done: cover property (pop);
   c_block_drop: cover property (blk_q && idle && save_fall);

endmodule

// *** rtl/sew_pkg.sv ***
// Purpose: shared constants and types for the serial word memory access block
// Assumes: reference clock of 125 MHz, words of at most 16 bits, 16 words
// Notes: long times are kept in their printed units; all but the store request low time are turned into cycles here
package sew_pkg;

   // array geometry
   localparam int ADDR_W = 4;
   localparam int WORDS = 16;
   localparam int WORD_LONG = 16;
   localparam int WORD_SHORT = 14;
   localparam int CNT_W = 5;
   localparam int TMR_W = 32;

   // clock rate
   localparam int CLK_PERIOD_NS = 8;
   localparam int REF_HZ = 125_000_000;

   // address settling window, printed in seconds
   localparam int T_SETTLE_S = 10;
   localparam int SETTLE_CYC_DEF = T_SETTLE_S * REF_HZ;
   // latest first data bit after the read start, in ns; a longest time rounds down
   localparam int T_FIRST_BIT_NS = 50_000;
   localparam int FIRST_BIT_CYC = T_FIRST_BIT_NS / CLK_PERIOD_NS;
   // least low time of the store request, kept by the controller
   localparam int T_SAVE_LOW_US = 50;
   // internal erase and write time, in seconds
   localparam int T_PROG_S = 1;
   localparam int PROG_CYC_DEF = T_PROG_S * REF_HZ;
   // cycles from a request edge at the pin to the first output bit
   localparam int OUT_LATENCY_CYC = 5;

   // strap level and reset values
   localparam logic STRAP_LONG = 1'h0;
   localparam logic CLR_IND_RST = 1'h0;
   localparam logic BUSY_RST = 1'h0;
   localparam logic OE_RST = 1'h0;
   localparam logic SOUT_IDLE = 1'h1;
   localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
   localparam logic [TMR_W-1:0] TMR_MAX = 32'hFFFF_FFFF;

   // control states
   typedef enum logic [1:0] {
      SEW_IDLE = 2'b00,
      SEW_READ = 2'b01,
      SEW_SHIFT = 2'b10,
      SEW_PROG = 2'b11
   } sew_state_t;

   // one word on its way to the array
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [WORD_LONG-1:0] data;
   } sew_word_t;

endpackage

// *** rtl/sew_buf.sv ***
// Purpose: small buffer with valid and ready on both sides
// Assumes: one clock, synchronous active-low reset, depth a power of two
// Notes: full and empty come from the pointer distance, never from a guess
`timescale 1ns/1ps
module sew_buf #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW:0] wr_q;
   logic [PW:0] rd_q;
   logic [PW:0] level;
   logic push;
   logic pop;

   // refuse depths that the pointer arithmetic cannot serve
   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("sew_buf: DEPTH must be a power of two of at least 2");
   end

   // occupancy and handshakes
   assign level = wr_q - rd_q;
   assign in_ready = (level != FULL);
   assign out_valid = (level != '0);
   assign out_data = mem_q[rd_q[PW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointers carry one extra bit so that full and empty differ
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_q + (PW + 1)'(push);
         rd_q <= rd_q + (PW + 1)'(pop);
      end
   end

   // storage holds no reset; only written slots are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[PW-1:0]] <= in_data;
      end
   end

   a_buf_no_overflow: assert property (@(posedge clk) disable iff (!rst_b) level <= FULL)
      else $error("buffer holds more words than its depth");
   c_buf_full: cover property (@(posedge clk) disable iff (!rst_b) level == FULL);

endmodule

// *** tb/sew_ctrl_model.sv ***
// Purpose: behavioural tuning controller driving the request pins and the serial link
// Assumes: shift clock stands low between frames; pin level is resolved by the bench
// Notes: reads collect up to 18 bits so that bits held past the word are seen too
`timescale 1ns/1ps
module sew_ctrl_model #(
   parameter int WAIT_CYC = 6250
) (
   // reference timing and pin level
   input wire logic ref_clk,
   input wire logic sout_pin,
   // request pins
   output logic fetch_n,
   output logic save_n,
   output logic [sew_pkg::ADDR_W-1:0] word_index,
   // serial link
   output logic shift_clk,
   output logic serial_in,
   // collected read word
   output logic rd_done,
   output logic [sew_pkg::WORD_LONG+1:0] rd_word
);
   import sew_pkg::*;

   // idle levels at time zero
   initial begin
      fetch_n = 1'h1;
      save_n = 1'h1;
      word_index = 4'h0;
      shift_clk = 1'h0;
      serial_in = 1'h0;
      rd_done = 1'h0;
      rd_word = '0;
   end

   // 48 ns link clock across the reset release; the link side needs falls on both sides of it
   task automatic spin(input int n);
      repeat (n) begin
         #6 shift_clk = 1'h1;
         #24 shift_clk = 1'h0;
         #18;
      end
   endtask

   // one pulse of a 48 ns period; the long low part lets the next bit settle,
   // and data flips after the fall so stale data never looks held
   task automatic pulse();
      #3 shift_clk = 1'h1;
      #12 shift_clk = 1'h0;
      #1 serial_in = ~serial_in;
      #32;
   endtask

   // read: sample a bit, then clock to the next one
   task automatic do_read(input logic [ADDR_W-1:0] a, input int nbits);
      logic [WORD_LONG+1:0] w;
      w = '0;
      @(posedge ref_clk);
      word_index <= a; // four parallel lines
      repeat (4) @(posedge ref_clk);
      fetch_n <= 1'h0; // address stable around the edge
      repeat (40) @(posedge ref_clk);
      word_index <= ~a; // moved only after the settle time
      @(negedge ref_clk); // sample away from the edge that moves the output
      for (int k = 0; k < nbits; k++) begin
         w = {w[WORD_LONG:0], sout_pin};
         pulse(); // one pulse per bit, extras only when asked
      end
      @(posedge ref_clk);
      rd_word <= w;
      rd_done <= 1'h1;
      @(posedge ref_clk);
      rd_done <= 1'h0;
      fetch_n <= 1'h1;
      word_index <= a;
   endtask

   // rewrite: request, wait out the quiet time, shift the word msb first
   task automatic do_write(input logic [ADDR_W-1:0] a, input int len, input logic [WORD_LONG-1:0] d);
      @(posedge ref_clk);
      word_index <= a;
      repeat (4) @(posedge ref_clk);
      save_n <= 1'h0; // held low until programming is over, a little past 50 us
      repeat (8) @(posedge ref_clk);
      word_index <= ~a; // busy must block this move
      repeat (WAIT_CYC) @(posedge ref_clk); // clocks no sooner than 50 us
      for (int k = len - 1; k >= 0; k--) begin
         serial_in = d[k]; // msb first, len pulses
         pulse();
      end
   endtask

   // store request back to high once programming is over
   task automatic release_save();
      @(posedge ref_clk);
      save_n <= 1'h1;
   endtask

   // short store request, used where it should be refused and to start the rewrite that hard clear aborts
   task automatic poke_save();
      @(posedge ref_clk);
      save_n <= 1'h0;
      repeat (10) @(posedge ref_clk);
      save_n <= 1'h1;
   endtask
endmodule

// *** tb/sew_access_tb.sv ***
// Purpose: self-checking bench for the serial word memory access block
// Assumes: short settle and programming counts so the run stays brief
// Notes: read results go through a queue of expected words and a watcher process
`timescale 1ns/1ps
module sew_access_tb;
   import sew_pkg::*;
   localparam int SETTLE_T = 20;
   localparam int PROG_T = 50;
   logic ref_clk, rst_b, hard_clear_n, strap;
   logic fetch_n, save_n, shift_clk, serial_in, rd_done;
   logic sout_o, sout_oe, busy, clr_ind_n;
   logic [ADDR_W-1:0] word_index, a;
   logic [WORD_LONG-1:0] d;
   logic [WORD_LONG+1:0] rd_word;
   logic [WORD_LONG+1:0] exp_q[$];
   logic [WORD_LONG-1:0] mem [WORDS];
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed, n;
   wire logic sout_pin;

   // open drain with pull-up: released pin reads high
   assign sout_pin = sout_oe ? sout_o : 1'h1;

   sew_access #(.SETTLE_CYC(TMR_W'(SETTLE_T)), .PROG_CYC(TMR_W'(PROG_T))) sew_access_inst (
      .REF_CLK(ref_clk), .RST_B(rst_b), .HARD_CLEAR_N(hard_clear_n),
      .FETCH_REQUEST_N(fetch_n), .SAVE_REQUEST_N(save_n), .WORD_INDEX(word_index),
      .WORD_SIZE_STRAP(strap), .SHIFT_CLK(shift_clk), .SERIAL_IN(serial_in),
      .SERIAL_OUT_O(sout_o), .SERIAL_OUT_OE(sout_oe), .PROGRAM_BUSY(busy), .CLEAR_IND_N(clr_ind_n));

   sew_ctrl_model sew_ctrl_model_inst (
      .ref_clk(ref_clk), .sout_pin(sout_pin), .fetch_n(fetch_n), .save_n(save_n),
      .word_index(word_index), .shift_clk(shift_clk), .serial_in(serial_in),
      .rd_done(rd_done), .rd_word(rd_word));

   // reference clock, 8 ns
   initial begin
      ref_clk = 1'h0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      num_checks++;
      if (seen !== expd) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // hang guard, well above the roughly 27k cycles the tests need
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         give_verdict();
      end
   end

   // bits seen in order: len bits msb first, then the last bit held
   function automatic logic [WORD_LONG+1:0] exp_word(input logic [WORD_LONG-1:0] v, input int len, input int extra);
      logic [WORD_LONG+1:0] w;
      w = '0;
      for (int k = len - 1; k >= 0; k--) w = {w[WORD_LONG:0], v[k]};
      repeat (extra) w = {w[WORD_LONG:0], v[0]};
      return w;
   endfunction

   // watcher: each finished read takes the oldest note
   always @(posedge rd_done) begin
      #1;
      check(rd_word, exp_q.pop_front());
      check(sout_oe, 1'h1);
   end

   task automatic rd(input logic [ADDR_W-1:0] ra, input int len, input int extra);
      exp_q.push_back(exp_word(mem[ra], len, extra));
      sew_ctrl_model_inst.do_read(ra, len + extra);
      repeat (6) @(negedge ref_clk);
      check(sout_oe, 1'h0);
      check(sout_pin, 1'h1);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] wa, input int len, input logic [WORD_LONG-1:0] wd);
      sew_ctrl_model_inst.do_write(wa, len, wd);
      @(negedge ref_clk);
      check(busy, 1'h1);
      n = 0;
      while (busy !== 1'h0 && n < 500) begin
         @(negedge ref_clk);
         n++;
      end
      check(n >= PROG_T - 10 && n <= PROG_T + 10, 1'h1);
      sew_ctrl_model_inst.release_save();
      mem[wa] = (len == WORD_SHORT) ? {2'h0, wd[13:0]} : wd;
   endtask

   // main sequence
   initial begin
      seed = 99;
      rst_b = 1'h0;
      hard_clear_n = 1'h1;
      strap = 1'h0;
      // link reset needs falling edges before and after the release
      fork
         sew_ctrl_model_inst.spin(5);
         begin
            repeat (15) @(posedge ref_clk);
            @(negedge ref_clk);
            check(clr_ind_n, 1'h0);
            check(sout_oe, 1'h0);
            check(busy, 1'h0);
            @(posedge ref_clk);
            rst_b <= 1'h1;
         end
      join
      repeat (5) @(negedge ref_clk);
      check(clr_ind_n, 1'h1);
      $display("reset test done");
      // long words: write, refused second store, read back with extra clocks
      for (int i = 0; i < 3; i++) begin
         a = 4'(i * 5 + 3);
         d = 16'($random(seed));
         wr(a, WORD_LONG, d);
         sew_ctrl_model_inst.poke_save();
         repeat (10) @(negedge ref_clk);
         check(busy, 1'h0);
         rd(a, WORD_LONG, 2);
      end
      $display("long word test done");
      // short words: open strap, upper bits come back as zero in long mode
      @(posedge ref_clk);
      strap <= 1'h1;
      d = 16'($random(seed));
      wr(4'hF, WORD_SHORT, d);
      rd(4'hF, WORD_SHORT, 0);
      @(posedge ref_clk);
      strap <= 1'h0;
      rd(4'hF, WORD_LONG, 0);
      $display("short word test done");
      // hard clear aborts a rewrite in progress and leaves the array intact
      sew_ctrl_model_inst.poke_save();
      @(negedge ref_clk);
      check(busy, 1'h1);
      @(posedge ref_clk);
      hard_clear_n <= 1'h0;
      fork
         sew_ctrl_model_inst.spin(4);
         repeat (14) @(negedge ref_clk);
      join
      @(negedge ref_clk);
      check(clr_ind_n, 1'h0);
      check(busy, 1'h0);
      @(posedge ref_clk);
      hard_clear_n <= 1'h1;
      repeat (6) @(negedge ref_clk);
      check(clr_ind_n, 1'h1);
      rd(4'hF, WORD_LONG, 0);
      rd(4'h3, WORD_LONG, 0);
      $display("hard clear test done");
      repeat (4) @(posedge ref_clk);
      give_verdict();
   end
endmodule
